// File: eeprom_cfg.svh
// Constants for the serial EEPROM command link.
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define ADDR_W 8
`define DATA_W 16
`define WORDS 256
`define OP_CTRL 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3
`define SUB_WRITE_DISABLE 2'h0
`define SUB_WRITE_ALL 2'h1
`define SUB_ERASE_ALL 2'h2
`define SUB_WEN 2'h3
`define ERASED_WORD 16'hFFFF
`define CLK_NS 8
`define PROGRAM_TIME_NS 10000
`define PROGRAM_CYCLES ((`PROGRAM_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define CLOCK_DIV 4
`endif

// File: eeprom_pkg.sv
// Types shared by both ends of the serial EEPROM link.
package eeprom_pkg;
  typedef enum logic [2:0] {
    cmd_read, cmd_write, cmd_erase, write_disable_cmd, write_enable_cmd, write_all_cmd, erase_all_cmd, cmd_none
  } cmd_t;
endpackage

// File: eeprom_link_if.sv
// Interface joining the serial bus master and the EEPROM.
`timescale 1ns/1ns
interface eeprom_link_if;
  logic chip_select;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  modport device (input chip_select, input serial_clock, input serial_in, output serial_out, output serial_out_oe_n);
  modport host (output chip_select, output serial_clock, output serial_in, input serial_out, input serial_out_oe_n);
endinterface

// File: eeprom_program_timer.sv
// Self-timed programming cycle counter.
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_program_timer #(
  parameter int CYCLES = `PROGRAM_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [31:0] count;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        count <= 32'(CYCLES - 1);
      end else if (busy) begin
        if (count == 32'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end
endmodule

// File: eeprom_device.sv
// Device end: command shifter, decoder, array and programming status.
//
// Summary of operation
// [RULE_01] Write-disable takes effect when chip select falls.
// [RULE_02] Reads work regardless of write enable.
// [RULE_03] Word erase sets addressed word all ones.
// [RULE_04] Host drops select right after last bit.
// [RULE_05] Select fall starts timed programming; busy meanwhile.
// [RULE_06] Erase-all sets whole array to ones.
// [RULE_07] Control opcode, upper bits 00: write-disable.
// [RULE_08] Control opcode, upper bits 10: erase-all.
// [RULE_09] Upper 01 write-all with data; 11 enable.
// [RULE_10] Select high after programming: output shows busy/ready.
// [RULE_11] Output released whenever chip select low.
// [RULE_12] Select toggling never aborts programming.
// [RULE_13] Start bit clears ready indication.
// [RULE_14] Clearing start bit begins new command.
// [RULE_15] Host avoids commands while busy.
// [RULE_16] Host disables writes after programming.
// [RULE_17] Writes overwrite without prior erase.
// [RULE_18] Frame: start, two-bit opcode, eight-bit address.
// [RULE_19] Status visible without serial clock edges.
// [RULE_20] Powers up write-disabled.
// [RULE_21] Erases ignored while write-disabled.
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_device
  import eeprom_pkg::*;
#(
  parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES,
  parameter int WORDS = `WORDS
) (
  input wire logic clk,
  input wire logic resetn,
  eeprom_link_if.device link,
  output logic write_enabled,
  output logic program_busy
);
  typedef enum {idle, opcode, address, data, read_out, hold} state_t;

  function automatic cmd_t decode(input logic [1:0] op, input logic [1:0] sub);
    if (op == `OP_READ) return cmd_read;
    if (op == `OP_WRITE) return cmd_write;
    if (op == `OP_ERASE) return cmd_erase;
    if (sub == `SUB_WRITE_DISABLE) return write_disable_cmd; // [RULE_07]
    if (sub == `SUB_ERASE_ALL) return erase_all_cmd; // [RULE_08]
    if (sub == `SUB_WRITE_ALL) return write_all_cmd; // [RULE_09]
    return write_enable_cmd; // [RULE_09]
  endfunction

  logic [15:0] mem [WORDS];
  logic [1:0] cs_sync, clock_sync, in_sync;
  logic cs_d, clock_d;
  state_t state;
  logic [4:0] bit_count;
  logic [1:0] op;
  logic [7:0] addr;
  logic [15:0] shift;
  logic [16:0] out_shift;
  cmd_t pending;
  logic status_shown;
  logic prog_start;
  logic prog_all;
  logic [7:0] prog_addr;
  logic [15:0] prog_data;
  logic prog_done;

  wire cs = cs_sync[1];
  wire clock_rise = clock_sync[1] && !clock_d;
  wire cs_fall = cs_d && !cs;
  wire cs_rise = !cs_d && cs;
  wire din = in_sync[1];
  wire cmd_t cmd_now = decode(op, addr[6:5]);
  wire allowed = write_enabled && !program_busy;

  eeprom_program_timer #(.CYCLES(PROGRAM_CYCLES)) u_eeprom_program_timer (
    .clk(clk),
    .resetn(resetn),
    .start(prog_start),
    .busy(program_busy), // [RULE_12]
    .done(prog_done)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_sync <= 2'h0;
      clock_sync <= 2'h0;
      in_sync <= 2'h0;
      cs_d <= 1'b0;
      clock_d <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], link.chip_select};
      clock_sync <= {clock_sync[0], link.serial_clock};
      in_sync <= {in_sync[0], link.serial_in};
      cs_d <= cs;
      clock_d <= clock_sync[1];
    end
  end

  // The array is written only when programming completes; a start bit during busy is ignored, so no read runs before then.
  always_ff @(posedge clk) begin
    if (prog_done) begin
      for (int i = 0; i < WORDS; i++) begin
        if (prog_all || 8'(i) == prog_addr) begin
          mem[i] <= prog_data; // [RULE_03] [RULE_06] [RULE_17]
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= idle;
      bit_count <= 5'h0;
      op <= 2'h0;
      addr <= 8'h0;
      shift <= 16'h0;
      out_shift <= 17'h0;
      pending <= cmd_none;
      write_enabled <= 1'b0; // [RULE_20]
      status_shown <= 1'b0;
      prog_start <= 1'b0;
      prog_all <= 1'b0;
      prog_addr <= 8'h0;
      prog_data <= 16'h0;
      link.serial_out <= 1'b0;
      link.serial_out_oe_n <= 1'b1;
    end else begin
      prog_start <= 1'b0;
      if (cs_fall) begin
        state <= idle; // [RULE_14]
        link.serial_out_oe_n <= 1'b1; // [RULE_11]
        // The released output is parked low so that a later status poll never starts from a stale high level.
        link.serial_out <= 1'b0;
        if (state == hold && allowed) begin
          unique case (pending)
            write_disable_cmd: write_enabled <= 1'b0; // [RULE_01]
            write_enable_cmd: write_enabled <= 1'b1;
            cmd_erase, erase_all_cmd, cmd_write, write_all_cmd: begin
              prog_start <= 1'b1; // [RULE_05] [RULE_21]
              status_shown <= 1'b1;
            end
            default: ;
          endcase
        end else if (state == hold && pending == write_enable_cmd && !program_busy) begin
          write_enabled <= 1'b1;
        end
        pending <= cmd_none;
      end else if (cs_rise && status_shown) begin
        link.serial_out_oe_n <= 1'b0; // [RULE_19]
        link.serial_out <= !program_busy; // [RULE_10]
      end else if (cs) begin
        if (status_shown && !link.serial_out_oe_n) begin
          link.serial_out <= !program_busy; // [RULE_10]
        end
        if (clock_rise) begin
          unique case (state)
            idle: if (din && !program_busy) begin
              state <= opcode; // [RULE_14] [RULE_18]
              bit_count <= 5'h0;
              if (status_shown) begin
                status_shown <= 1'b0;
                link.serial_out_oe_n <= 1'b1; // [RULE_13]
              end
            end
            opcode: begin
              op <= {op[0], din};
              bit_count <= bit_count + 5'h1;
              if (bit_count == 5'h1) begin
                state <= address;
                bit_count <= 5'h0;
              end
            end
            address: begin
              addr <= {addr[6:0], din};
              bit_count <= bit_count + 5'h1;
              if (bit_count == 5'h7) begin
                bit_count <= 5'h0;
                pending <= decode(op, addr[6:5]);
                if (op == `OP_READ) begin
                  state <= read_out; // [RULE_02]
                  // The dummy zero goes out now, so the first shift of the read must already show D15.
                  out_shift <= {mem[{addr[6:0], din}], 1'b0};
                  link.serial_out <= 1'b0;
                  link.serial_out_oe_n <= 1'b0;
                end else if (cmd_now == write_all_cmd || op == `OP_WRITE) begin
                  state <= data;
                end else begin
                  state <= hold; // [RULE_04]
                  prog_all <= cmd_now == erase_all_cmd;
                  prog_addr <= {addr[6:0], din};
                  prog_data <= `ERASED_WORD;
                end
              end
            end
            data: begin
              shift <= {shift[14:0], din};
              bit_count <= bit_count + 5'h1;
              if (bit_count == 5'hF) begin
                state <= hold;
                prog_all <= pending == write_all_cmd;
                prog_addr <= addr;
                prog_data <= {shift[14:0], din};
              end
            end
            read_out: begin
              out_shift <= {out_shift[15:0], 1'b0};
              link.serial_out <= out_shift[16];
            end
            hold: state <= idle;
            default: state <= idle;
          endcase
        end
      end
    end
  end
endmodule

// File: eeprom_host.sv
// Host end: serial bus master issuing one command per request.
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_host
  import eeprom_pkg::*;
#(
  parameter int CLOCK_DIV = `CLOCK_DIV
) (
  input wire logic clk,
  input wire logic resetn,
  eeprom_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire cmd_t req_cmd,
  input wire logic [7:0] req_addr,
  input wire logic [15:0] req_data,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  typedef enum {idle, shift_out, gap, poll} state_t;

  function automatic logic [26:0] frame(input cmd_t c, input logic [7:0] a, input logic [15:0] d);
    unique case (c)
      cmd_read: return {1'b1, `OP_READ, a, 16'h0};
      cmd_write: return {1'b1, `OP_WRITE, a, d};
      cmd_erase: return {1'b1, `OP_ERASE, a, 16'h0};
      write_disable_cmd: return {1'b1, `OP_CTRL, `SUB_WRITE_DISABLE, 6'h0, 16'h0}; // [RULE_16]
      write_all_cmd: return {1'b1, `OP_CTRL, `SUB_WRITE_ALL, 6'h0, d};
      erase_all_cmd: return {1'b1, `OP_CTRL, `SUB_ERASE_ALL, 6'h0, 16'h0};
      default: return {1'b1, `OP_CTRL, `SUB_WEN, 6'h0, 16'h0};
    endcase
  endfunction

  logic [1:0] so_sync;
  state_t state;
  logic [26:0] sreg;
  logic [5:0] bits;
  logic [31:0] div;
  logic is_read, is_prog;
  logic [16:0] rx;
  wire tick = div == 32'(CLOCK_DIV - 1);

  assign req_ready = state == idle;

  always_ff @(posedge clk) begin
    if (!resetn) so_sync <= 2'h0;
    else so_sync <= {so_sync[0], link.serial_out};
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= idle;
      sreg <= 27'h0;
      bits <= 6'h0;
      div <= 32'h0;
      is_read <= 1'b0;
      is_prog <= 1'b0;
      rx <= 17'h0;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0;
      link.chip_select <= 1'b0;
      link.serial_clock <= 1'b0;
      link.serial_in <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      div <= tick ? 32'h0 : div + 32'h1;
      unique case (state)
        idle: if (req_valid) begin
          sreg <= frame(req_cmd, req_addr, req_data);
          is_read <= req_cmd == cmd_read;
          is_prog <= req_cmd inside {cmd_write, cmd_erase, write_all_cmd, erase_all_cmd};
          bits <= (req_cmd == cmd_write || req_cmd == write_all_cmd || req_cmd == cmd_read) ? 6'd27 : 6'd11;
          link.chip_select <= 1'b1;
          div <= 32'h0;
          state <= shift_out;
        end
        shift_out: if (tick) begin
          link.serial_clock <= !link.serial_clock;
          if (link.serial_clock) begin
            if (bits == 6'h0) begin
              link.chip_select <= 1'b0; // [RULE_04]
              link.serial_clock <= 1'b0;
              state <= gap;
            end
          end else begin
            link.serial_in <= sreg[26];
            sreg <= {sreg[25:0], 1'b0};
            bits <= bits - 6'h1;
            if (is_read && bits <= 6'd16) rx <= {rx[15:0], so_sync[1]};
          end
        end
        gap: if (tick) begin
          link.serial_in <= 1'b0;
          if (is_read) begin
            rsp_data <= {rx[14:0], so_sync[1]};
          end
          if (is_prog) begin
            link.chip_select <= 1'b1; // [RULE_15] [RULE_19]
            state <= poll;
          end else begin
            rsp_valid <= 1'b1;
            state <= idle;
          end
        end
        // A released output reads as ready, as a pull-up would show it; a refused erase never drives status.
        poll: if (tick && (link.serial_out_oe_n || so_sync[1])) begin
          link.chip_select <= 1'b0; // [RULE_14]
          rsp_valid <= 1'b1;
          state <= idle;
        end
        default: state <= idle;
      endcase
    end
  end
endmodule

// File: eeprom_link_checker.sv
// Concurrent assertions on the EEPROM link wires and device status levels.
`timescale 1ns/1ns
`include "eeprom_cfg.svh"
module eeprom_link_checker #(
  parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  input wire logic write_enabled,
  input wire logic program_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  int busy_len;
  // Counts the busy cycles so that the length of a programming cycle can be judged when it ends.
  always_ff @(posedge clk) begin
    if (!resetn || !program_busy) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  // The sync flops delay the output by a few cycles, so the release and busy rules wait five cycles of steady select, the start rule six.
  property p_release_low; !chip_select [*5] |-> serial_out_oe_n; endproperty
  property p_show_busy; chip_select [*5] ##0 program_busy |-> !serial_out_oe_n && !serial_out; endproperty
  property p_show_ready; $fell(program_busy) && chip_select |-> ##[0:4] (!serial_out_oe_n && serial_out); endproperty
  property p_busy_len; $fell(program_busy) |-> busy_len >= PROGRAM_CYCLES - 1 && busy_len <= PROGRAM_CYCLES + 1; endproperty
  property p_start_on_fall; chip_select [*6] |-> !$rose(program_busy); endproperty
  property p_enable_idle; $changed(write_enabled) |-> !program_busy; endproperty
  property p_no_busy_disabled; !write_enabled && !program_busy |=> !program_busy; endproperty
  property p_clear_ready;
    $rose(serial_clock) && serial_in && chip_select && !serial_out_oe_n && serial_out && !program_busy
      |-> ##[1:6] serial_out_oe_n;
  endproperty
  a_release_low: assert property (p_release_low) else $error("output driven while deselected");
  a_show_busy: assert property (p_show_busy) else $error("busy not shown low");
  a_show_ready: assert property (p_show_ready) else $error("ready not shown high");
  a_busy_len: assert property (p_busy_len) else $error("programming length wrong");
  a_start_on_fall: assert property (p_start_on_fall) else $error("busy began with select high");
  a_enable_idle: assert property (p_enable_idle) else $error("enable changed while busy");
  a_no_busy_disabled: assert property (p_no_busy_disabled) else $error("busy while disabled");
  a_clear_ready: assert property (p_clear_ready) else $error("ready not cleared");
  c_busy: cover property ($rose(program_busy));
  c_ready: cover property (!serial_out_oe_n && serial_out);
  c_enable: cover property ($rose(write_enabled));
endmodule

// File: serial_eeprom_erase_status_bench.sv
// Self-checking bench joining host and device ends of the EEPROM link.
`timescale 1ns/1ns
module serial_eeprom_erase_status_bench;
  import eeprom_pkg::*;
  localparam int PROG = 20;
  logic clk = 0;
  logic resetn = 0;
  logic req_valid = 0;
  cmd_t req_cmd = cmd_none;
  logic [7:0] req_addr = 8'h00;
  logic [15:0] req_data = 16'h0000;
  logic req_ready, rsp_valid, write_enabled, program_busy;
  logic [15:0] rsp_data;
  logic saw_busy = 0;
  logic clock_q = 0;
  logic first_bit = 0;
  int fails = 0;
  int num_checks = 0;
  int sk_rises = 0;
  eeprom_link_if link();
  eeprom_device #(.PROGRAM_CYCLES(PROG), .WORDS(256)) u_eeprom_device (.clk(clk), .resetn(resetn),
    .link(link.device), .write_enabled(write_enabled), .program_busy(program_busy));
  eeprom_host #(.CLOCK_DIV(4)) u_eeprom_host (.clk(clk), .resetn(resetn), .link(link.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  eeprom_link_checker #(.PROGRAM_CYCLES(PROG)) u_eeprom_link_checker (.clk(clk), .resetn(resetn),
    .chip_select(link.chip_select), .serial_clock(link.serial_clock), .serial_in(link.serial_in),
    .serial_out(link.serial_out), .serial_out_oe_n(link.serial_out_oe_n), .write_enabled(write_enabled),
    .program_busy(program_busy));
  initial forever #4 clk = ~clk;
  // Watches the wire: counts serial clock rises of a frame and keeps its first bit.
  always @(posedge clk) begin
    clock_q <= link.serial_clock;
    if (program_busy === 1'b1) saw_busy <= 1'b1;
    if (link.chip_select && link.serial_clock && !clock_q) begin
      if (sk_rises == 0) first_bit <= link.serial_in;
      sk_rises <= sk_rises + 1;
    end
  end
  task automatic close_out();
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Issues one request and waits for its response, both under a bounded count.
  task automatic run(input cmd_t c, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    sk_rises = 0;
    saw_busy = 0;
    req_cmd = c;
    req_addr = a;
    req_data = d;
    req_valid = 1;
    @(negedge clk);
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000) begin
      fails++;
      close_out();
    end else begin
      // Enable and disable land a few cycles after select falls, behind the sync flops.
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    run(cmd_read, a, 16'h0000);
    check(rsp_data, exp, "read data");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1;
    check(16'(write_enabled), 16'h0001 ^ 16'h0001, "power-up enable");
    run(erase_all_cmd, 8'h80, 16'h0000);
    check(16'(saw_busy), 16'h0000, "erase-all while disabled");
    run(write_enable_cmd, 8'hC0, 16'h0000);
    check(16'(write_enabled), 16'h0001, "enable");
    run(cmd_write, 8'h05, 16'h1234);
    rd(8'h05, 16'h1234);
    run(cmd_write, 8'h05, 16'h00FF);
    rd(8'h05, 16'h00FF);
    run(cmd_erase, 8'h05, 16'h0000);
    check(16'(saw_busy), 16'h0001, "erase busy");
    rd(8'h05, 16'hFFFF);
    run(write_all_cmd, 8'h7F, 16'hA5A5);
    rd(8'h00, 16'hA5A5);
    rd(8'hFF, 16'hA5A5);
    run(cmd_write, 8'h10, 16'h0000);
    run(erase_all_cmd, 8'hBF, 16'h0000);
    check(16'(saw_busy), 16'h0001, "erase-all busy");
    rd(8'h00, 16'hFFFF);
    rd(8'h10, 16'hFFFF);
    run(write_disable_cmd, 8'h3F, 16'h0000);
    check(16'(sk_rises), 16'h000B, "frame clock count");
    check(16'(first_bit), 16'h0001, "start bit");
    check(16'(write_enabled), 16'h0000, "disable");
    run(cmd_erase, 8'h10, 16'h0000);
    check(16'(saw_busy), 16'h0000, "erase while disabled");
    run(cmd_write, 8'h10, 16'h1111);
    check(16'(saw_busy), 16'h0000, "write while disabled");
    rd(8'h10, 16'hFFFF);
    close_out();
  end
endmodule
